// [stmu_pkg.sv]
// Package: register map, field layout, reset values and state records of the unit.
package stmu_pkg;

  // ==========================================================
  // Register map, byte addresses of aligned 32-bit words.
  localparam logic [7:0] STMU_OFS_CMD = 8'h00;
  localparam logic [7:0] STMU_OFS_OPA = 8'h04;
  localparam logic [7:0] STMU_OFS_OPB = 8'h08;
  localparam logic [7:0] STMU_OFS_ACC_LO = 8'h0C;
  localparam logic [7:0] STMU_OFS_ACC_HI = 8'h10;
  localparam logic [7:0] STMU_OFS_RES_LO = 8'h14;
  localparam logic [7:0] STMU_OFS_RES_HI = 8'h18;
  localparam logic [7:0] STMU_OFS_CUR = 8'h1C;
  localparam logic [7:0] STMU_OFS_SAV = 8'h20;
  localparam logic [7:0] STMU_OFS_STAT = 8'h24;

  // ==========================================================
  // Command word fields.
  localparam int STMU_CMD_OP_LSB = 0;
  localparam int STMU_CMD_FLAGS_BIT = 4;
  localparam int STMU_CMD_COND_BIT = 5;
  localparam int STMU_CMD_IMM_BIT = 6;
  localparam int STMU_CMD_IMM8_LSB = 8;
  localparam int STMU_CMD_ROT_LSB = 16;

  // ==========================================================
  // Status word layout and reset values.
  localparam int STMU_SW_N = 31;
  localparam int STMU_SW_Z = 30;
  localparam int STMU_SW_C = 29;
  localparam int STMU_SW_V = 28;
  localparam logic [31:0] STMU_SW_DEFINED = 32'hF000_00DF;
  localparam logic [31:0] STMU_CUR_RESET = 32'h0000_00D3;
  localparam logic [31:0] STMU_SAV_RESET = 32'h0000_0000;
  localparam logic [4:0] STMU_MODE_USER = 5'h10;

  // Unit status register bits.
  localparam int STMU_STAT_DONE = 0;
  localparam int STMU_STAT_SKIP = 1;
  localparam int STMU_STAT_BUSY = 2;

  // Radix-4 steps for a 34-bit extended multiplier.
  localparam int STMU_BOOTH_STEPS = 17;

  // ==========================================================
  // Types.
  typedef enum logic [3:0] {
    OP_NONE, OP_RD_CUR, OP_RD_SAV, OP_WR_CUR_FULL, OP_WR_CUR_FLAGS,
    OP_WR_SAV_FULL, OP_WR_SAV_FLAGS, OP_MUL_SHORT, OP_MUL_SHORT_ACC,
    OP_MUL_LONG_U, OP_MUL_LONG_S, OP_MUL_LONG_U_ACC, OP_MUL_LONG_S_ACC
  } stmu_op_t;

  typedef enum logic {ST_IDLE, ST_MUL} stmu_fsm_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } stmu_avs_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] cnt;
    logic [65:0] mcand;
    logic [33:0] mplier;
    logic prev;
    logic [65:0] acc;
  } stmu_booth_t;

  typedef struct packed {
    stmu_fsm_t fsm;
    stmu_op_t op;
    logic set_flags;
    logic mul_start;
    logic [31:0] cmd;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] acc_lo;
    logic [31:0] acc_hi;
    logic [31:0] res_lo;
    logic [31:0] res_hi;
    logic [31:0] cur;
    logic [31:0] sav;
    logic done;
    logic skipped;
    logic waitreq;
    logic [31:0] rdata;
  } stmu_state_t;

  localparam stmu_state_t STMU_STATE_RESET = '{fsm: ST_IDLE, op: OP_NONE,
    waitreq: 1'b1, cur: STMU_CUR_RESET, sav: STMU_SAV_RESET, default: '0};

endpackage : stmu_pkg

// [stmu_booth.sv]
// Iterative radix-4 Booth multiplier, 32x32 to 64 bits, signed or unsigned.
`timescale 1ns/1ps
`default_nettype none
module stmu_booth (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic signed_mode,
  input wire logic [31:0] mcand,
  input wire logic [31:0] mplier,
  output logic done,
  output logic [63:0] product
);
  import stmu_pkg::*;

  stmu_booth_t s_reg;
  stmu_booth_t s_next;
  logic [65:0] part;

  // ==========================================================
  // One Booth digit per clock; the multiplier is widened by two bits and the multiplicand to 66 bits
  // so that the unsigned forms never see a false sign.
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    part = '0;
    if (start) begin
      s_next.busy = 1'b1;
      s_next.cnt = '0;
      s_next.mcand = {{34{signed_mode & mcand[31]}}, mcand};
      s_next.mplier = {{2{signed_mode & mplier[31]}}, mplier};
      s_next.prev = 1'b0;
      s_next.acc = '0;
    end else if (s_reg.busy) begin
      unique case ({s_reg.mplier[1:0], s_reg.prev})
        3'b000, 3'b111: part = '0;
        3'b001, 3'b010: part = s_reg.mcand;
        3'b011: part = s_reg.mcand << 1;
        3'b100: part = -(s_reg.mcand << 1);
        3'b101, 3'b110: part = -s_reg.mcand;
      endcase
      s_next.acc = s_reg.acc + part;
      s_next.mcand = s_reg.mcand << 2;
      s_next.mplier = s_reg.mplier >> 2;
      s_next.prev = s_reg.mplier[1];
      s_next.cnt = s_reg.cnt + 5'h01;
      if (s_reg.cnt == 5'(STMU_BOOTH_STEPS - 1)) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
  assign product = s_reg.acc[63:0];

endmodule : stmu_booth
`default_nettype wire

// [stmu_unit.sv]
// Status word transfer and multiply unit with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
module stmu_unit (
  input wire logic clock,
  input wire logic rst,
  input wire stmu_pkg::stmu_avs_req_t av_req,
  output logic av_waitrequest,
  output logic [31:0] av_readdata,
  output logic [31:0] cur_status
);
  import stmu_pkg::*;

  stmu_state_t s_reg;
  stmu_state_t s_next;

  logic req;
  logic commit;
  logic wr_commit;
  logic cmd_wr;
  logic cond_bit;
  logic exec;
  logic exec_mul;
  logic user_mode;
  logic is_short;
  logic is_acc;
  logic mul_done;
  logic fin;
  logic [31:0] rd_mux;
  logic [31:0] wmerge;
  logic [31:0] stat_word;
  logic [31:0] src;
  logic [3:0] src_flags;
  logic [63:0] imm_rot;
  logic [63:0] product;
  logic [31:0] short_res;
  logic [63:0] long_res;
  stmu_op_t cmd_op;

  // ==========================================================
  // Bus decode.
  // A request is answered only while no multiply runs, so operands
  // cannot change under the multiplier.
  assign req = av_req.read | av_req.write;
  assign commit = req & ~s_reg.waitreq;
  assign wr_commit = commit & av_req.write;
  assign cmd_wr = wr_commit & (av_req.address == STMU_OFS_CMD);
  assign cond_bit = wmerge[STMU_CMD_COND_BIT];
  assign cmd_op = stmu_op_t'(wmerge[STMU_CMD_OP_LSB +: 4]);
  assign exec = cmd_wr & cond_bit;
  assign exec_mul = exec & (cmd_op inside {[OP_MUL_SHORT:OP_MUL_LONG_S_ACC]});
  assign user_mode = s_reg.cur[4:0] == STMU_MODE_USER;

  // Status register of the unit itself.
  always_comb begin
    stat_word = '0;
    stat_word[STMU_STAT_DONE] = s_reg.done;
    stat_word[STMU_STAT_SKIP] = s_reg.skipped;
    stat_word[STMU_STAT_BUSY] = s_reg.fsm != ST_IDLE;
  end

  // ==========================================================
  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    unique case (av_req.address)
      STMU_OFS_CMD: rd_mux = s_reg.cmd;
      STMU_OFS_OPA: rd_mux = s_reg.opa;
      STMU_OFS_OPB: rd_mux = s_reg.opb;
      STMU_OFS_ACC_LO: rd_mux = s_reg.acc_lo;
      STMU_OFS_ACC_HI: rd_mux = s_reg.acc_hi;
      STMU_OFS_RES_LO: rd_mux = s_reg.res_lo;
      STMU_OFS_RES_HI: rd_mux = s_reg.res_hi;
      STMU_OFS_CUR: rd_mux = s_reg.cur;
      STMU_OFS_SAV: rd_mux = s_reg.sav;
      STMU_OFS_STAT: rd_mux = stat_word;
      default: rd_mux = '0;
    endcase
  end

  // Byte enables merge new lanes over the current register contents.
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmerge[8*b +: 8] = av_req.byteenable[b] ? av_req.writedata[8*b +: 8] : rd_mux[8*b +: 8];
  end

  // ==========================================================
  // Source of a status write: operand register or rotated immediate.
  // The rotate moves the 8-bit value right by twice the rotate field.
  assign imm_rot = {2{24'h00_0000, wmerge[STMU_CMD_IMM8_LSB +: 8]}} >> {wmerge[STMU_CMD_ROT_LSB +: 4], 1'b0};
  assign src = wmerge[STMU_CMD_IMM_BIT] ? imm_rot[31:0] : s_reg.opa;
  assign src_flags = src[STMU_SW_V +: 4];

  // ==========================================================
  // Multiplier. Operands are latched registers, so any sharing of the
  // core's register numbers among them cannot corrupt the product.
  stmu_booth u_booth (
    .clock(clock),
    .rst(rst),
    .start(s_reg.mul_start),
    .signed_mode(s_reg.op == OP_MUL_LONG_S || s_reg.op == OP_MUL_LONG_S_ACC),
    .mcand(s_reg.opa),
    .mplier(s_reg.opb),
    .done(mul_done),
    .product(product)
  );

  // Result shaping after the multiplier finishes.
  // The short forms run unsigned: the low word does not depend on sign.
  assign is_short = s_reg.op == OP_MUL_SHORT || s_reg.op == OP_MUL_SHORT_ACC;
  assign is_acc = s_reg.op inside {OP_MUL_SHORT_ACC, OP_MUL_LONG_U_ACC, OP_MUL_LONG_S_ACC};
  assign short_res = product[31:0] + (is_acc ? s_reg.acc_lo : 32'h0000_0000);
  assign long_res = product + (is_acc ? {s_reg.acc_hi, s_reg.acc_lo} : 64'h0);
  assign fin = (s_reg.fsm == ST_MUL) & mul_done;

  // ==========================================================
  // Next state of the whole unit.
  always_comb begin
    s_next = s_reg;
    s_next.mul_start = 1'b0;
    s_next.waitreq = 1'b1;

    // Answer one cycle after the request appears, unless busy.
    if (req && s_reg.waitreq && s_reg.fsm == ST_IDLE) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = av_req.read ? rd_mux : 32'h0000_0000;
    end

    // Operand registers; result and status words are read-only here.
    if (wr_commit) begin
      unique case (av_req.address)
        STMU_OFS_OPA: s_next.opa = wmerge;
        STMU_OFS_OPB: s_next.opb = wmerge;
        STMU_OFS_ACC_LO: s_next.acc_lo = wmerge;
        STMU_OFS_ACC_HI: s_next.acc_hi = wmerge;
        default: ;
      endcase
    end

    // A command write always completes; a false condition only marks it.
    if (cmd_wr) begin
      s_next.cmd = wmerge;
      s_next.done = 1'b1;
      s_next.skipped = ~cond_bit;
    end

    if (exec) begin
      s_next.op = cmd_op;
      s_next.set_flags = wmerge[STMU_CMD_FLAGS_BIT];
      unique case (cmd_op)
        OP_NONE: ;
        OP_RD_CUR: s_next.res_lo = s_reg.cur;
        OP_RD_SAV: begin
          // User mode has no saved word; the access is dropped.
          if (!user_mode) begin
            s_next.res_lo = s_reg.sav;
          end
        end
        OP_WR_CUR_FULL: begin
          if (user_mode) begin
            s_next.cur[STMU_SW_V +: 4] = src_flags;
          end else begin
            s_next.cur = src & STMU_SW_DEFINED;
          end
        end
        OP_WR_CUR_FLAGS: s_next.cur[STMU_SW_V +: 4] = src_flags;
        OP_WR_SAV_FULL: begin
          if (!user_mode) begin
            s_next.sav = src & STMU_SW_DEFINED;
          end
        end
        OP_WR_SAV_FLAGS: begin
          if (!user_mode) begin
            s_next.sav[STMU_SW_V +: 4] = src_flags;
          end
        end
        OP_MUL_SHORT, OP_MUL_SHORT_ACC, OP_MUL_LONG_U, OP_MUL_LONG_S,
        OP_MUL_LONG_U_ACC, OP_MUL_LONG_S_ACC: begin
          s_next.fsm = ST_MUL;
          s_next.mul_start = 1'b1;
          s_next.done = 1'b0;
        end
        default: ;
      endcase
    end

    // Write back the product; C and V are left as they were.
    if (fin) begin
      s_next.fsm = ST_IDLE;
      s_next.done = 1'b1;
      if (is_short) begin
        s_next.res_lo = short_res;
        if (s_reg.set_flags) begin
          s_next.cur[STMU_SW_N] = short_res[31];
          s_next.cur[STMU_SW_Z] = short_res == 32'h0000_0000;
        end
      end else begin
        s_next.res_lo = long_res[31:0];
        s_next.res_hi = long_res[63:32];
        if (s_reg.set_flags) begin
          s_next.cur[STMU_SW_N] = long_res[63];
          s_next.cur[STMU_SW_Z] = long_res == 64'h0;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= STMU_STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign av_waitrequest = s_reg.waitreq;
  assign av_readdata = s_reg.rdata;
  assign cur_status = s_reg.cur;

  // ==========================================================
  // Checks. A reference product is formed with the plain operator at the
  // moment a multiply is issued, independent of the Booth datapath.
  logic [63:0] ref_calc;
  logic [63:0] ref_reg;

  always_comb begin
    ref_calc = 64'h0;
    unique case (cmd_op)
      OP_MUL_SHORT: ref_calc = {32'h0000_0000, s_reg.opa * s_reg.opb};
      OP_MUL_SHORT_ACC: ref_calc = {32'h0000_0000, s_reg.opa * s_reg.opb + s_reg.acc_lo};
      OP_MUL_LONG_U: ref_calc = {32'h0000_0000, s_reg.opa} * {32'h0000_0000, s_reg.opb};
      OP_MUL_LONG_U_ACC: ref_calc = {32'h0000_0000, s_reg.opa} * {32'h0000_0000, s_reg.opb}
        + {s_reg.acc_hi, s_reg.acc_lo};
      OP_MUL_LONG_S: ref_calc = {{32{s_reg.opa[31]}}, s_reg.opa} * {{32{s_reg.opb[31]}}, s_reg.opb};
      OP_MUL_LONG_S_ACC: ref_calc = {{32{s_reg.opa[31]}}, s_reg.opa} * {{32{s_reg.opb[31]}}, s_reg.opb}
        + {s_reg.acc_hi, s_reg.acc_lo};
      default: ref_calc = 64'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ref_reg <= 64'h0;
    end else if (exec_mul) begin
      ref_reg <= ref_calc;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  user_ctrl_keep_a: assert property (
    exec && cmd_op == OP_WR_CUR_FULL && user_mode
    |=> $stable(s_reg.cur[27:0]) && s_reg.cur[31:28] == $past(src_flags))
    else $error("User mode full write changed control bits.");

  priv_full_write_a: assert property (
    exec && cmd_op == OP_WR_CUR_FULL && !user_mode
    |=> s_reg.cur == ($past(src) & STMU_SW_DEFINED))
    else $error("Privileged full write did not load the status word.");

  defined_bits_a: assert property (
    (s_reg.cur & ~STMU_SW_DEFINED) == 32'h0000_0000
    && (s_reg.sav & ~STMU_SW_DEFINED) == 32'h0000_0000)
    else $error("Undefined status bit is set.");

  flags_only_a: assert property (
    exec && cmd_op == OP_WR_CUR_FLAGS
    |=> s_reg.cur[31:28] == $past(src_flags) && $stable(s_reg.cur[27:0]))
    else $error("Flags-only write disturbed the word.");

  cond_false_a: assert property (
    cmd_wr && !cond_bit
    |=> $stable(s_reg.cur) && $stable(s_reg.sav) && $stable(s_reg.res_lo)
    && s_reg.skipped && s_reg.fsm == ST_IDLE)
    else $error("Instruction with false condition changed state.");

  mul_latency_a: assert property (
    exec_mul |-> ##19 s_reg.fsm == ST_MUL ##1 s_reg.fsm == ST_IDLE && s_reg.done)
    else $error("Multiply did not finish in twenty cycles.");

  short_result_a: assert property (
    fin && is_short |=> s_reg.res_lo == ref_reg[31:0])
    else $error("Short multiply result wrong.");

  long_result_a: assert property (
    fin && !is_short |=> {s_reg.res_hi, s_reg.res_lo} == ref_reg)
    else $error("Long multiply result wrong.");

  short_flags_a: assert property (
    fin && is_short && s_reg.set_flags
    |=> s_reg.cur[STMU_SW_N] == s_reg.res_lo[31] && s_reg.cur[STMU_SW_Z] == (s_reg.res_lo == 32'h0000_0000)
    && $stable(s_reg.cur[STMU_SW_V]))
    else $error("Short multiply flags wrong.");

  long_flags_a: assert property (
    fin && !is_short && s_reg.set_flags
    |=> s_reg.cur[STMU_SW_N] == s_reg.res_hi[31]
    && s_reg.cur[STMU_SW_Z] == ({s_reg.res_hi, s_reg.res_lo} == 64'h0))
    else $error("Long multiply flags wrong.");

  short_acc_c: cover property (exec && cmd_op == OP_MUL_SHORT_ACC);
  long_signed_acc_c: cover property (exec && cmd_op == OP_MUL_LONG_S_ACC ##20 s_reg.done);
  user_full_write_c: cover property (exec && cmd_op == OP_WR_CUR_FULL && user_mode);
  cond_false_c: cover property (cmd_wr && !cond_bit);

endmodule : stmu_unit
`default_nettype wire

// [stmu_host_model.sv]
// Bus master model that stands in for the core's decoder and register file.
`timescale 1ns/1ps
`default_nettype none
module stmu_host_model (
  input wire logic clock,
  output var stmu_pkg::stmu_avs_req_t av_req,
  input wire logic av_waitrequest,
  input wire logic [31:0] av_readdata
);
  import stmu_pkg::*;

  // ==========================================================
  // Idle bus at time zero.
  initial av_req = '{read: 1'b0, write: 1'b0, address: 8'h00, writedata: 32'h0000_0000, byteenable: 4'h0};

  // One Avalon transfer, held until waitrequest is sampled low.
  // Released address and data lines carry the inverse of the last value, so a stale value never looks valid.
  task automatic access(input logic is_wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
    @(posedge clock);
    av_req <= '{read: !is_wr, write: is_wr, address: addr, writedata: wdata, byteenable: 4'hF};
    do @(posedge clock); while (av_waitrequest !== 1'b0);
    rdata = av_readdata;
    av_req <= '{read: 1'b0, write: 1'b0, address: ~addr, writedata: ~wdata, byteenable: 4'h0};
  endtask : access
endmodule : stmu_host_model
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the status transfer and multiply unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import stmu_pkg::*;

  // The whole run needs well under a thousand cycles; the ceiling leaves room for stalls.
  localparam int TIMEOUT_CYCLES = 5000;
  logic clock;
  logic rst;
  stmu_avs_req_t av_req;
  logic av_waitrequest;
  logic [31:0] av_readdata;
  logic [31:0] cur_status;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  // ==========================================================
  // Clock, unit and bus master.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  stmu_unit dut_u (.clock(clock), .rst(rst), .av_req(av_req), .av_waitrequest(av_waitrequest),
    .av_readdata(av_readdata), .cur_status(cur_status));
  stmu_host_model host_u (.clock(clock), .av_req(av_req), .av_waitrequest(av_waitrequest),
    .av_readdata(av_readdata));

  // ==========================================================
  // Shared helpers.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    host_u.access(1'b1, a, d, unused);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host_u.access(1'b0, a, 32'h0000_0000, d);
  endtask : rd

  function automatic logic [31:0] cmd(input logic [3:0] op, input logic s, input logic cond);
    cmd = 32'h0000_0000;
    cmd[STMU_CMD_OP_LSB +: 4] = op;
    cmd[STMU_CMD_FLAGS_BIT] = s;
    cmd[STMU_CMD_COND_BIT] = cond;
  endfunction : cmd

  // A status move is an operand write followed by the command; the effect is seen by a later read.
  task automatic status_op(input logic [3:0] op, input logic [31:0] src);
    wr(STMU_OFS_OPA, src);
    wr(STMU_OFS_CMD, cmd(op, 1'b0, 1'b1));
  endtask : status_op

  // Reads the current word through the bus and compares it and the status port.
  task automatic check_cur(input string what, input logic [31:0] exp);
    logic [31:0] d;
    rd(STMU_OFS_CUR, d);
    check(what, d, exp);
    check(what, cur_status, exp);
  endtask : check_cur

  // ==========================================================
  // Scenarios.
  task automatic test_reset();
    logic [31:0] d;
    check_cur("cur at reset", STMU_CUR_RESET);
    rd(STMU_OFS_SAV, d);
    check("sav at reset", d, STMU_SAV_RESET);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, d);
    check("unmapped read", d, 32'h0000_0000);
    wr(STMU_OFS_CUR, 32'h0000_0000);
    check_cur("cur is read only", STMU_CUR_RESET);
  endtask : test_reset

  // Privileged full write, then a mode change by read, modify and write back.
  task automatic test_full_priv();
    logic [31:0] d;
    status_op(OP_WR_CUR_FULL, 32'hFFFF_FFFF);
    check_cur("full write", 32'hF000_00DF);
    rd(STMU_OFS_CUR, d);
    d = (d & ~32'h0000_001F) | 32'h0000_0013;
    status_op(OP_WR_CUR_FULL, d);
    check_cur("mode change", 32'hF000_00D3);
  endtask : test_full_priv

  // Flags-only writes from a register and from a rotated immediate.
  task automatic test_flags();
    status_op(OP_WR_CUR_FLAGS, 32'h5FFF_FF00);
    check_cur("flags from reg", 32'h5000_00D3);
    // Immediate 0x0A rotated right by 4; here the immediate feeds a flags-only write.
    wr(STMU_OFS_CMD, cmd(OP_WR_CUR_FLAGS, 1'b0, 1'b1) | 32'h0002_0A40);
    check_cur("flags from imm", 32'hA000_00D3);
  endtask : test_flags

  task automatic test_saved();
    logic [31:0] d;
    status_op(OP_WR_SAV_FULL, 32'hFFFF_FFFF);
    status_op(OP_WR_SAV_FLAGS, 32'h3000_0000);
    rd(STMU_OFS_SAV, d);
    check("sav flags", d, 32'h3000_00DF);
    status_op(OP_RD_SAV, 32'h0000_0000);
    rd(STMU_OFS_RES_LO, d);
    check("sav to reg", d, 32'h3000_00DF);
    status_op(OP_RD_CUR, 32'h0000_0000);
    rd(STMU_OFS_RES_LO, d);
    check("cur to reg", d, 32'hA000_00D3);
  endtask : test_saved

  // A false condition leaves status and results alone and reports the skip.
  task automatic test_cond_false();
    logic [31:0] d;
    logic [31:0] old_res;
    rd(STMU_OFS_RES_LO, old_res);
    wr(STMU_OFS_OPA, 32'h0000_0000);
    wr(STMU_OFS_CMD, cmd(OP_WR_CUR_FULL, 1'b0, 1'b0));
    rd(STMU_OFS_STAT, d);
    check("skip stat", d, (32'h1 << STMU_STAT_DONE) | (32'h1 << STMU_STAT_SKIP));
    wr(STMU_OFS_OPB, 32'h0000_0005);
    wr(STMU_OFS_CMD, cmd(OP_MUL_SHORT, 1'b1, 1'b0));
    rd(STMU_OFS_RES_LO, d);
    check("skip res", d, old_res);
    check_cur("skip cur", 32'hA000_00D3);
  endtask : test_cond_false

  // One multiply with its expectation worked out here; operands stand for distinct, non-PC registers.
  task automatic mul_case(input logic [3:0] op, input logic s, input logic [31:0] a, b, lo, hi);
    logic [63:0] ea, eb, exp;
    logic [31:0] d, prev, mask;
    logic lng, sg, acc, n, z;
    lng = op >= OP_MUL_LONG_U;
    sg = (op == OP_MUL_LONG_S) || (op == OP_MUL_LONG_S_ACC);
    acc = (op == OP_MUL_SHORT_ACC) || (op == OP_MUL_LONG_U_ACC) || (op == OP_MUL_LONG_S_ACC);
    ea = sg ? {{32{a[31]}}, a} : {32'h0000_0000, a};
    eb = sg ? {{32{b[31]}}, b} : {32'h0000_0000, b};
    exp = ea * eb + (acc ? {lng ? hi : 32'h0000_0000, lo} : 64'h0000_0000_0000_0000);
    n = lng ? exp[63] : exp[31];
    z = lng ? (exp == 64'h0000_0000_0000_0000) : (exp[31:0] == 32'h0000_0000);
    // The status port is read over the bus first, because the last status write lands on the edge that ends it.
    rd(STMU_OFS_CUR, prev);
    wr(STMU_OFS_OPA, a);
    wr(STMU_OFS_OPB, b);
    wr(STMU_OFS_ACC_LO, lo);
    wr(STMU_OFS_ACC_HI, hi);
    wr(STMU_OFS_CMD, cmd(op, s, 1'b1));
    rd(STMU_OFS_STAT, d);
    check("mul stat", d, 32'h1 << STMU_STAT_DONE);
    rd(STMU_OFS_RES_LO, d);
    check("mul res lo", d, exp[31:0]);
    if (lng) begin
      rd(STMU_OFS_RES_HI, d);
      check("mul res hi", d, exp[63:32]);
    end
    // Carry is meaningless after any multiply, overflow too after a long one.
    mask = !s ? 32'hFFFF_FFFF : (lng ? 32'hCFFF_FFFF : 32'hDFFF_FFFF);
    check("mul flags", cur_status & mask, (s ? {n, z, prev[29:0]} : prev) & mask);
  endtask : mul_case

  task automatic test_short_mul();
    status_op(OP_WR_CUR_FLAGS, 32'h1000_0000);
    mul_case(OP_MUL_SHORT, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
    mul_case(OP_MUL_SHORT, 1'b1, 32'h8000_0000, 32'h0000_0002, 32'h1234_5678, 32'h0000_0000);
    mul_case(OP_MUL_SHORT_ACC, 1'b1, 32'h0000_0007, 32'hFFFF_FFFD, 32'hFFFF_FFFD, 32'h7777_0000);
    mul_case(OP_MUL_SHORT_ACC, 1'b0, 32'h1234_5678, 32'h9ABC_DEF0, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask : test_short_mul

  task automatic test_long_mul();
    mul_case(OP_MUL_LONG_U, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
    mul_case(OP_MUL_LONG_S, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000);
    mul_case(OP_MUL_LONG_U, 1'b1, 32'h0001_0000, 32'h0001_0000, 32'h0000_0000, 32'h0000_0000);
    mul_case(OP_MUL_LONG_S, 1'b0, 32'h8000_0000, 32'h8000_0000, 32'h0000_0000, 32'h0000_0000);
    mul_case(OP_MUL_LONG_U_ACC, 1'b1, 32'hFFFF_FFFF, 32'h0000_0002, 32'hFFFF_FFFF, 32'h0000_0001);
    mul_case(OP_MUL_LONG_S_ACC, 1'b1, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000);
  endtask : test_long_mul

  // Runs last: user mode cannot be left again, and the saved word is never touched from here.
  task automatic test_user();
    logic [31:0] d;
    logic [31:0] base;
    rd(STMU_OFS_CUR, d);
    base = (d & ~32'h0000_001F) | {27'h0, STMU_MODE_USER};
    status_op(OP_WR_CUR_FULL, base);
    check_cur("enter user", base);
    status_op(OP_WR_CUR_FULL, 32'h5000_001F);
    check_cur("user full write", {4'h5, base[27:0]});
    status_op(OP_WR_CUR_FLAGS, 32'hC000_0000);
    check_cur("user flags write", {4'hC, base[27:0]});
  endtask : test_user

  // ==========================================================
  // Main sequence and hang guard.
  initial begin
    rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_full_priv();
    test_flags();
    test_saved();
    test_cond_false();
    test_short_mul();
    test_long_mul();
    test_user();
    end_of_test();
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      n_mismatch++;
      end_of_test();
    end
  end
endmodule : tb_top
`default_nettype wire
